// ---- src/awg_pkg.sv ----
// Shared constants and types for the arbitrary waveform sequencer
package awg_pkg;
  // Clock and base tick
  localparam int CLK_HZ = 20_000_000;
  localparam int CLK_PERIOD_NS = 1_000_000_000 / CLK_HZ;
  localparam int BASE_TICK_NS = 1000;
  localparam int BASE_TICK_CYC = (BASE_TICK_NS / CLK_PERIOD_NS < 1) ? 1 : BASE_TICK_NS / CLK_PERIOD_NS;
  localparam int US_PER_S = 1_000_000;
  // Sample memory
  localparam int DEPTH = 1600;
  localparam int IDX_W = 11;
  localparam logic [IDX_W-1:0] IDX_LAST = 11'h63f;
  // Register byte offsets
  localparam logic [7:0] OFF_TYPE = 8'h00;
  localparam logic [7:0] OFF_DLY = 8'h04;
  localparam logic [7:0] OFF_DIV = 8'h08;
  localparam logic [7:0] OFF_CYC = 8'h0c;
  localparam logic [7:0] OFF_END = 8'h10;
  localparam logic [7:0] OFF_RUN = 8'h14;
  localparam logic [7:0] OFF_RST = 8'h18;
  localparam logic [7:0] OFF_SET = 8'h1c;
  localparam logic [7:0] OFF_REPLY = 8'h20;
  localparam logic [7:0] OFF_PTS = 8'h24;
  localparam logic [7:0] OFF_GIDX = 8'h28;
  localparam logic [7:0] OFF_GDAT = 8'h2c;
  localparam logic [7:0] OFF_STAT = 8'h30;
  localparam logic [7:0] OFF_BOOST = 8'h34;
  // Field positions of the sample-load word
  localparam int SET_IDX_LSB = 16;
  // Limits
  localparam logic [10:0] DIV_MAX = 11'h400;
  localparam logic [10:0] CYC_MAX = 11'h400;
  localparam logic [3:0] TYPE_POT = 4'h0;
  localparam logic [3:0] TYPE_1A = 4'h1;
  localparam logic [3:0] TYPE_NORM_MAX = 4'ha;
  localparam logic signed [15:0] LIM_POT = 16'sh3a98;
  localparam logic signed [15:0] LIM_GAL_1A = 16'sh03e8;
  localparam logic signed [15:0] LIM_GAL = 16'sh07d0;
  // Run instructions
  localparam logic [1:0] RUN_STOP = 2'h0;
  localparam logic [1:0] RUN_START = 2'h1;
  localparam logic [1:0] RUN_ARM = 2'h2;
  // Reply codes
  localparam logic [7:0] REP_OK = 8'h00;
  localparam logic [7:0] REP_NO_TYPE = 8'h01;
  localparam logic [7:0] REP_BAD_IDX = 8'h02;
  localparam logic [7:0] REP_BAD_VAL = 8'h03;
  localparam logic [15:0] ERR_NO_VALUE = 16'h001f;
  // Boost register default
  localparam logic [3:0] BOOST_CODE_RESET = 4'hd;

  typedef struct packed {
    logic defined;
    logic [3:0] wtype;
    logic [9:0] dly;
    logic [10:0] div;
    logic [10:0] cyc;
    logic end_open;
  } awg_cfg_t;

  localparam awg_cfg_t CFG_RESET = '{defined: 1'b0, wtype: 4'h0, dly: 10'h000,
                                     div: 11'h001, cyc: 11'h001, end_open: 1'b0};

  typedef enum logic [1:0] {ST_IDLE, ST_ARMED, ST_HOLD, ST_PLAY} awg_state_t;
endpackage

// ---- src/awg_tick.sv ----
// Base tick generator: one-cycle pulse every N clocks while running
`timescale 1ns/100ps
module awg_tick #(
  parameter int N = 20
) (
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic run_in,
  output logic tick_out
);
  localparam int FIRST = (N > 1) ? 1 : 0;
  logic [15:0] cnt_q;
  wire last = (cnt_q == 16'(N - 1));

  always_ff @(posedge clk_in) begin
    if (reset_in || !run_in) begin
      // Preload by one so the registered first tick still lands N cycles after start
      cnt_q <= 16'(FIRST);
      tick_out <= 1'b0;
    end else begin
      cnt_q <= last ? 16'h0000 : cnt_q + 16'h0001;
      tick_out <= last;
    end
  end
endmodule // awg_tick

// ---- src/awg_seq.sv ----
// Arbitrary waveform sequencer with AHB-Lite register slave
// Behaviour
// [RULE1] Step to next sample every divider microseconds
// [RULE2] Reset command stops and restores defaults
// [RULE3] Sample loads refused until type chosen
// [RULE4] Point count read-only, counts loaded samples
// [RULE5] First sample held extra whole seconds
// [RULE6] Base rate 1 MHz, divider 1..1024
// [RULE7] Finite scan end holds first or opens
// [RULE8] Zero cycles loops forever, else plays count
// [RULE9] Load by index, play from index zero
// [RULE10] Sample value range depends on type
// [RULE11] Each sample load returns reply code
// [RULE12] Host reads every reply before continuing
// [RULE13] Readback gives 31 for unloaded index
// [RULE14] Type set only once between resets
// [RULE15] Type code picks mode and range
// [RULE16] Start or arm switches to type's range
// [RULE17] Boosted accepts booster code, normal 0..10
// [RULE18] Stop opens loop and disarms
// [RULE19] Start closes loop, plays at once
// [RULE20] Arm closes loop, waits trigger falling edge
// [RULE21] Only latest armed generator launches on trigger
// [RULE22] Bad index or value rejected, memory unchanged
//
// Our own choices: the AHB-Lite interface to the registers and the address map.
`timescale 1ns/100ps
module awg_seq #(
  parameter int US_PER_S = awg_pkg::US_PER_S
) (
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic hsel_in,
  input wire logic [31:0] haddr_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic [2:0] hsize_in,
  input wire logic [31:0] hwdata_in,
  input wire logic hready_in,
  output logic [31:0] hrdata_out,
  output logic hreadyout_out,
  output logic hresp_out,
  input wire logic scan_trig_in,
  input wire logic other_armed_in,
  output logic armed_out,
  output logic [15:0] sample_out,
  output logic sample_strobe_out,
  output logic loop_closed_out,
  output logic galvano_out,
  output logic [3:0] range_out,
  output logic running_out
);
  awg_pkg::awg_cfg_t cfg_q;
  awg_pkg::awg_state_t st_q;
  logic [15:0] mem [awg_pkg::DEPTH];
  logic [awg_pkg::DEPTH-1:0] valid_q;
  logic [10:0] pts_q;
  logic [7:0] reply_q;
  logic pend_q;
  logic [10:0] gidx_q;
  logic boost_q;
  logic [3:0] bcode_q;
  logic wen_q;
  logic [7:0] waddr_q;
  logic [10:0] idx_q;
  logic [10:0] div_cnt_q;
  logic [19:0] us_q;
  logic [9:0] sec_q;
  logic [10:0] cyc_q;
  logic trig_prev_q;
  logic step_q;
  logic us_tick;

  // Bus decode
  wire addr_ok = hsel_in && htrans_in[1] && hready_in;
  wire rd_now = addr_ok && !hwrite_in;
  wire [7:0] raddr = haddr_in[7:0];
  wire [7:0] reg_off = waddr_q;
  wire wr_type = wen_q && reg_off == awg_pkg::OFF_TYPE;
  wire wr_dly = wen_q && reg_off == awg_pkg::OFF_DLY;
  wire wr_div = wen_q && reg_off == awg_pkg::OFF_DIV;
  wire wr_cyc = wen_q && reg_off == awg_pkg::OFF_CYC;
  wire wr_end = wen_q && reg_off == awg_pkg::OFF_END;
  wire wr_run = wen_q && reg_off == awg_pkg::OFF_RUN;
  wire wr_rst = wen_q && reg_off == awg_pkg::OFF_RST;
  wire wr_set = wen_q && reg_off == awg_pkg::OFF_SET;
  wire wr_gidx = wen_q && reg_off == awg_pkg::OFF_GIDX;
  wire wr_boost = wen_q && reg_off == awg_pkg::OFF_BOOST;
  wire rd_reply = rd_now && raddr == awg_pkg::OFF_REPLY;
  wire [1:0] run_code = hwdata_in[1:0];
  wire run_stop = wr_run && run_code == awg_pkg::RUN_STOP;
  wire run_go = wr_run && run_code == awg_pkg::RUN_START && cfg_q.defined;
  wire run_arm = wr_run && run_code == awg_pkg::RUN_ARM && cfg_q.defined;

  // Type acceptance depends on booster mode
  wire [3:0] new_type = hwdata_in[3:0];
  wire type_legal = boost_q ? (new_type == bcode_q) : (new_type <= awg_pkg::TYPE_NORM_MAX); // [RULE15] [RULE17]
  wire type_take = wr_type && !cfg_q.defined && type_legal && hwdata_in[31:4] == 28'h0; // [RULE14]

  // Sample load checks
  wire [10:0] set_idx = hwdata_in[awg_pkg::SET_IDX_LSB +: awg_pkg::IDX_W];
  wire signed [15:0] set_val = hwdata_in[15:0];
  wire signed [15:0] lim = (cfg_q.wtype == awg_pkg::TYPE_POT) ? awg_pkg::LIM_POT :
                           (cfg_q.wtype == awg_pkg::TYPE_1A) ? awg_pkg::LIM_GAL_1A : awg_pkg::LIM_GAL; // [RULE10]
  wire idx_bad = set_idx > awg_pkg::IDX_LAST || hwdata_in[31:27] != 5'h00;
  wire val_bad = set_val > lim || set_val < -lim;
  wire [7:0] set_code = !cfg_q.defined ? awg_pkg::REP_NO_TYPE : // [RULE3]
                        idx_bad ? awg_pkg::REP_BAD_IDX :
                        val_bad ? awg_pkg::REP_BAD_VAL : awg_pkg::REP_OK; // [RULE22]
  wire set_ok = wr_set && set_code == awg_pkg::REP_OK;
  wire set_new = set_ok && !valid_q[set_idx];

  // Playback timing
  wire playing = st_q == awg_pkg::ST_HOLD || st_q == awg_pkg::ST_PLAY;
  wire trig_fall = trig_prev_q && !scan_trig_in; // [RULE20]
  wire launch = run_go || (st_q == awg_pkg::ST_ARMED && trig_fall && !wr_run); // [RULE19]
  wire sec_end = us_tick && us_q == 20'(US_PER_S - 1);
  wire hold_done = sec_end && sec_q + 10'h001 == cfg_q.dly; // [RULE5]
  wire step = st_q == awg_pkg::ST_PLAY && us_tick && div_cnt_q == cfg_q.div - 11'h001; // [RULE1]
  wire [10:0] last_idx = (pts_q == 11'h000) ? 11'h000 : pts_q - 11'h001;
  wire wrap = step && idx_q == last_idx;
  wire [10:0] cyc_next = cyc_q + 11'h001;
  wire finish = wrap && cfg_q.cyc != 11'h000 && cyc_next == cfg_q.cyc; // [RULE8]
  wire cmd_any = wr_run || wr_rst;

  // Readback
  wire gidx_ok = gidx_q <= awg_pkg::IDX_LAST;
  wire [15:0] g_err = (gidx_ok && valid_q[gidx_q]) ? 16'h0000 : awg_pkg::ERR_NO_VALUE; // [RULE13]
  wire [15:0] g_val = gidx_ok ? mem[gidx_q] : 16'h0000;
  wire [31:0] stat = {26'h0, boost_q, pend_q, cfg_q.defined, playing, st_q == awg_pkg::ST_ARMED, loop_closed_out};
  wire [31:0] rdata =
    raddr == awg_pkg::OFF_TYPE ? {27'h0, cfg_q.defined, cfg_q.wtype} :
    raddr == awg_pkg::OFF_DLY ? {22'h0, cfg_q.dly} :
    raddr == awg_pkg::OFF_DIV ? {21'h0, cfg_q.div} : // [RULE6]
    raddr == awg_pkg::OFF_CYC ? {21'h0, cfg_q.cyc} :
    raddr == awg_pkg::OFF_END ? {31'h0, cfg_q.end_open} :
    raddr == awg_pkg::OFF_REPLY ? {24'h0, reply_q} :
    raddr == awg_pkg::OFF_PTS ? {21'h0, pts_q} : // [RULE4]
    raddr == awg_pkg::OFF_GIDX ? {21'h0, gidx_q} :
    raddr == awg_pkg::OFF_GDAT ? {g_err, g_val} :
    raddr == awg_pkg::OFF_STAT ? stat :
    raddr == awg_pkg::OFF_BOOST ? {27'h0, bcode_q, boost_q} : 32'h0;

  awg_tick #(.N(awg_pkg::BASE_TICK_CYC)) u_tick (
    .clk_in(clk_in),
    .reset_in(reset_in),
    .run_in(playing),
    .tick_out(us_tick)
  );

  // Bus slave: zero wait states, always OKAY
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      wen_q <= 1'b0;
      waddr_q <= 8'h00;
      hrdata_out <= 32'h0;
      hreadyout_out <= 1'b1;
      hresp_out <= 1'b0;
    end else begin
      wen_q <= addr_ok && hwrite_in;
      waddr_q <= raddr;
      hreadyout_out <= 1'b1;
      hresp_out <= 1'b0;
      if (rd_now) begin
        hrdata_out <= rdata;
      end
    end
  end

  // Sample memory, no reset needed
  always_ff @(posedge clk_in) begin
    if (set_ok) begin
      mem[set_idx] <= set_val; // [RULE9]
    end
  end

  // Configuration and load bookkeeping
  always_ff @(posedge clk_in) begin
    if (reset_in || wr_rst) begin
      cfg_q <= awg_pkg::CFG_RESET; // [RULE2]
      valid_q <= '0;
      pts_q <= 11'h000;
      gidx_q <= 11'h000;
    end else begin
      if (type_take) begin
        cfg_q.defined <= 1'b1;
        cfg_q.wtype <= new_type;
      end
      if (wr_dly) begin
        cfg_q.dly <= hwdata_in[9:0];
      end
      if (wr_div && hwdata_in[10:0] != 11'h000 && hwdata_in[10:0] <= awg_pkg::DIV_MAX && hwdata_in[31:11] == 21'h0) begin
        cfg_q.div <= hwdata_in[10:0];
      end
      if (wr_cyc && hwdata_in[10:0] <= awg_pkg::CYC_MAX && hwdata_in[31:11] == 21'h0) begin
        cfg_q.cyc <= hwdata_in[10:0];
      end
      if (wr_end) begin
        cfg_q.end_open <= hwdata_in[0]; // [RULE7]
      end
      if (set_ok) begin
        valid_q[set_idx] <= 1'b1;
      end
      if (set_new) begin
        pts_q <= pts_q + 11'h001; // [RULE4]
      end
      if (wr_gidx) begin
        gidx_q <= hwdata_in[10:0];
      end
    end
  end

  // Reply code and pending flag; a new load wins over a clearing read
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      reply_q <= awg_pkg::REP_OK;
      pend_q <= 1'b0;
      boost_q <= 1'b0;
      bcode_q <= awg_pkg::BOOST_CODE_RESET;
    end else begin
      if (wr_set) begin
        reply_q <= set_code; // [RULE11]
      end
      pend_q <= wr_set || (pend_q && !rd_reply);
      if (wr_boost && !loop_closed_out) begin
        boost_q <= hwdata_in[0];
        bcode_q <= hwdata_in[4:1];
      end
    end
  end

  // Playback state machine
  always_ff @(posedge clk_in) begin
    if (reset_in || wr_rst || run_stop) begin
      st_q <= awg_pkg::ST_IDLE; // [RULE18]
      loop_closed_out <= 1'b0;
      idx_q <= 11'h000;
      div_cnt_q <= 11'h000;
      us_q <= 20'h0;
      sec_q <= 10'h000;
      cyc_q <= 11'h000;
      step_q <= 1'b0;
    end else begin
      step_q <= launch || step;
      if (run_go || run_arm) begin
        loop_closed_out <= 1'b1; // [RULE19] [RULE20]
      end
      unique case (st_q)
        awg_pkg::ST_IDLE: begin
          if (run_arm) begin
            st_q <= awg_pkg::ST_ARMED;
          end
        end
        awg_pkg::ST_ARMED: begin
          if (other_armed_in && !cmd_any) begin
            st_q <= awg_pkg::ST_IDLE; // [RULE21]
          end
        end
        awg_pkg::ST_HOLD: begin
          us_q <= sec_end ? 20'h0 : us_q + 20'(us_tick);
          if (sec_end) begin
            sec_q <= sec_q + 10'h001;
          end
          if (hold_done) begin
            st_q <= awg_pkg::ST_PLAY; // [RULE5]
          end
        end
        awg_pkg::ST_PLAY: begin
          if (us_tick) begin
            div_cnt_q <= step ? 11'h000 : div_cnt_q + 11'h001;
          end
          if (step) begin
            idx_q <= wrap ? 11'h000 : idx_q + 11'h001; // [RULE9]
          end
          if (wrap) begin
            cyc_q <= cyc_next;
          end
          if (finish) begin
            st_q <= awg_pkg::ST_IDLE;
            loop_closed_out <= !cfg_q.end_open; // [RULE7]
          end
        end
      endcase
      if (launch) begin
        st_q <= (cfg_q.dly == 10'h000) ? awg_pkg::ST_PLAY : awg_pkg::ST_HOLD;
        loop_closed_out <= 1'b1;
        idx_q <= 11'h000;
        div_cnt_q <= 11'h000;
        us_q <= 20'h0;
        sec_q <= 10'h000;
        cyc_q <= 11'h000;
      end
    end
  end

  // Outputs toward the analog loop
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      trig_prev_q <= 1'b1;
      sample_out <= 16'h0000;
      sample_strobe_out <= 1'b0;
      galvano_out <= 1'b0;
      range_out <= 4'h0;
      running_out <= 1'b0;
      armed_out <= 1'b0;
    end else begin
      trig_prev_q <= scan_trig_in;
      sample_out <= (pts_q == 11'h000) ? 16'h0000 : mem[idx_q];
      sample_strobe_out <= step_q;
      running_out <= playing;
      armed_out <= st_q == awg_pkg::ST_ARMED;
      if (run_go || run_arm) begin
        range_out <= cfg_q.wtype; // [RULE16]
        galvano_out <= cfg_q.wtype != awg_pkg::TYPE_POT;
      end
    end
  end

  // Checks
  a_type_once: assert property (@(posedge clk_in) disable iff (reset_in) // [RULE14]
    $past(cfg_q.defined) && !$past(wr_rst) |-> $stable(cfg_q.wtype))
    else $error("type changed without reset");
  a_load_no_type: assert property (@(posedge clk_in) disable iff (reset_in) // [RULE3]
    wr_set && !cfg_q.defined |=> reply_q == awg_pkg::REP_NO_TYPE && $stable(valid_q))
    else $error("load accepted without type");
  a_bad_load_kept: assert property (@(posedge clk_in) disable iff (reset_in) // [RULE22]
    wr_set && set_code != awg_pkg::REP_OK |=> $stable(valid_q) && $stable(pts_q) && reply_q != 8'h00)
    else $error("bad load changed memory");
  a_count_new: assert property (@(posedge clk_in) disable iff (reset_in) // [RULE4]
    set_new && !wr_rst |=> pts_q == $past(pts_q) + 11'h001)
    else $error("point count not advanced");
  a_reset_cmd: assert property (@(posedge clk_in) disable iff (reset_in) // [RULE2]
    wr_rst |=> cfg_q == awg_pkg::CFG_RESET && st_q == awg_pkg::ST_IDLE && pts_q == 11'h000)
    else $error("reset command left state");
  a_stop_open: assert property (@(posedge clk_in) disable iff (reset_in) // [RULE18]
    run_stop |=> st_q == awg_pkg::ST_IDLE && !loop_closed_out ##1 !armed_out)
    else $error("stop did not open and disarm");
  a_start_plays: assert property (@(posedge clk_in) disable iff (reset_in) // [RULE19]
    run_go && !wr_rst |=> loop_closed_out && playing && idx_q == 11'h000)
    else $error("start did not close loop and play");
  a_arm_waits: assert property (@(posedge clk_in) disable iff (reset_in) // [RULE20]
    st_q == awg_pkg::ST_ARMED && !trig_fall && !other_armed_in && !cmd_any |=> st_q == awg_pkg::ST_ARMED && loop_closed_out)
    else $error("armed scan left without trigger");
  a_other_disarm: assert property (@(posedge clk_in) disable iff (reset_in) // [RULE21]
    st_q == awg_pkg::ST_ARMED && other_armed_in && !cmd_any |=> st_q == awg_pkg::ST_IDLE)
    else $error("stale arm survived");
  a_step_timing: assert property (@(posedge clk_in) disable iff (reset_in) // [RULE1]
    step && !cmd_any |=> div_cnt_q == 11'h000 && idx_q == ($past(wrap) ? 11'h000 : $past(idx_q) + 11'h001))
    else $error("step did not advance index");
  a_div_range: assert property (@(posedge clk_in) disable iff (reset_in) // [RULE6]
    cfg_q.div != 11'h000 && cfg_q.div <= awg_pkg::DIV_MAX)
    else $error("divider out of range");
  a_end_cond: assert property (@(posedge clk_in) disable iff (reset_in) // [RULE7]
    finish && !cmd_any |=> st_q == awg_pkg::ST_IDLE && loop_closed_out == !$past(cfg_q.end_open))
    else $error("end condition not applied");
  c_start: cover property (@(posedge clk_in) disable iff (reset_in) run_go);
  c_trig_launch: cover property (@(posedge clk_in) disable iff (reset_in) st_q == awg_pkg::ST_ARMED && trig_fall);
  c_finish: cover property (@(posedge clk_in) disable iff (reset_in) finish);
endmodule // awg_seq

// ---- test/awg_host.sv ----
// Host model: AHB-Lite master issuing the register commands
`timescale 1ns/100ps
module awg_host (
  input wire logic clk_in,
  input wire logic hready_in,
  input wire logic [31:0] hrdata_in,
  output logic hsel_out,
  output logic [31:0] haddr_out,
  output logic [1:0] htrans_out,
  output logic hwrite_out,
  output logic [2:0] hsize_out,
  output logic [31:0] hwdata_out
);
  initial begin
    hsel_out = 1'b0;
    haddr_out = 32'h00000000;
    htrans_out = 2'h0;
    hwrite_out = 1'b0;
    hsize_out = 3'h2;
    hwdata_out = 32'h00000000;
  end

  // Called just after a rising edge; returns at the edge that ends the data phase
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    hsel_out <= 1'b1;
    haddr_out <= {24'h000000, a};
    htrans_out <= 2'h2;
    hwrite_out <= w;
    @(posedge clk_in);
    while (hready_in !== 1'b1) @(posedge clk_in);
    hsel_out <= 1'b0;
    htrans_out <= 2'h0;
    hwdata_out <= d;
    @(posedge clk_in);
    while (hready_in !== 1'b1) @(posedge clk_in);
    q = hrdata_in;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    xfer(1'b1, a, d, q);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    xfer(1'b0, a, 32'h00000000, q);
  endtask

  // Every sample load is followed by fetching its reply code
  task automatic load(input logic [10:0] idx, input logic [15:0] v, output logic [31:0] rep);
    wr(awg_pkg::OFF_SET, {5'h00, idx, v});
    rd(awg_pkg::OFF_REPLY, rep);
  endtask
endmodule // awg_host

// ---- test/awg_seq_tb.sv ----
// Self-checking bench for the arbitrary waveform sequencer
`timescale 1ns/100ps
module awg_seq_tb;
  logic clk_in = 1'b0;
  logic reset_in = 1'b1;
  logic trig = 1'b1;
  logic oth = 1'b0;
  logic hsel, hwrite, hready, hresp, armed, strobe, loop, galv, running;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, hrdata, r;
  logic [15:0] smp;
  logic [3:0] rng;
  logic [15:0] pts[4];
  logic [15:0] sq[$];
  int ts[$];
  int fail_count = 0;
  int checks_done = 0;
  int cyc = 0;
  int v;
  logic [7:0] doff[6] = '{awg_pkg::OFF_TYPE, awg_pkg::OFF_DLY, awg_pkg::OFF_DIV, awg_pkg::OFF_CYC,
                          awg_pkg::OFF_END, awg_pkg::OFF_PTS};
  logic [31:0] dval[6] = '{32'h0, 32'h0, 32'h1, 32'h1, 32'h0, 32'h0};

  always #25 clk_in = ~clk_in;

  awg_host host (.clk_in(clk_in), .hready_in(hready), .hrdata_in(hrdata), .hsel_out(hsel), .haddr_out(haddr),
    .htrans_out(htrans), .hwrite_out(hwrite), .hsize_out(hsize), .hwdata_out(hwdata));

  awg_seq #(.US_PER_S(5)) dut (.clk_in(clk_in), .reset_in(reset_in), .hsel_in(hsel), .haddr_in(haddr),
    .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(hsize), .hwdata_in(hwdata), .hready_in(hready),
    .hrdata_out(hrdata), .hreadyout_out(hready), .hresp_out(hresp), .scan_trig_in(trig),
    .other_armed_in(oth), .armed_out(armed), .sample_out(smp), .sample_strobe_out(strobe),
    .loop_closed_out(loop), .galvano_out(galv), .range_out(rng), .running_out(running));

  task automatic print_verdict;
    if (fail_count == 0 && checks_done > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // Strobe log with cycle stamps; also the hang guard
  always @(posedge clk_in) begin
    cyc++;
    if (strobe === 1'b1) begin
      sq.push_back(smp);
      ts.push_back(cyc);
    end
    if (cyc > 30000) begin
      fail_count++;
      print_verdict();
    end
  end

  task automatic cmp(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e) begin
      fail_count++;
      $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  function automatic logic [7:0] exp_rep(input logic defd, input int t, input int idx, input int x);
    int lim;
    lim = (t == 0) ? 15000 : (t == 1) ? 1000 : 2000;
    if (!defd) return 8'h01;
    if (idx > 1599) return 8'h02;
    if (x > lim || x < -lim) return 8'h03;
    return 8'h00;
  endfunction

  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    host.rd(a, r);
    cmp(r, e);
  endtask

  task automatic ld(input logic defd, input int t, input int idx, input int x);
    host.load(idx[10:0], x[15:0], r);
    cmp(r, {24'h0, exp_rep(defd, t, idx, x)});
  endtask

  task automatic chk_defaults;
    for (int i = 0; i < 6; i++) rdc(doff[i], dval[i]);
    cmp({31'h0, loop}, 32'h0);
  endtask

  task automatic play(input int n, input int g0, input int g, input logic fin, input logic endo);
    int k;
    ts.delete();
    sq.delete();
    host.wr(awg_pkg::OFF_RUN, 32'h1);
    for (k = 0; k < 20000 && (sq.size() < n || (fin && running !== 1'b0)); k++) @(posedge clk_in);
    cmp(k < 20000, 1);
    for (k = 0; k < n; k++) cmp({16'h0, sq[k]}, {16'h0, pts[k % 4]});
    for (k = 1; k < n; k++) cmp(ts[k] - ts[k-1], (k == 1) ? g0 : g);
    cmp({31'h0, running}, {31'h0, !fin});
    cmp({31'h0, loop}, {31'h0, !(fin && endo)});
    if (fin && !endo) cmp({16'h0, smp}, {16'h0, pts[0]});
  endtask

  task automatic fall;
    trig <= 1'b0;
    @(posedge clk_in);
    trig <= 1'b1;
    repeat (6) @(posedge clk_in);
  endtask

  task automatic disarm_try(input logic by_other);
    host.wr(awg_pkg::OFF_RUN, 32'h2);
    if (by_other) begin
      oth <= 1'b1;
      @(posedge clk_in);
      oth <= 1'b0;
    end else begin
      host.wr(awg_pkg::OFF_RUN, 32'h0);
    end
    repeat (2) @(posedge clk_in);
    sq.delete();
    fall();
    cmp({30'h0, armed, running}, 32'h0);
    cmp(sq.size(), 0);
    host.wr(awg_pkg::OFF_RUN, 32'h0);
  endtask

  initial begin
    r = $urandom(83884);
    repeat (16) @(posedge clk_in);
    reset_in <= 1'b0;
    @(posedge clk_in);
    chk_defaults();
    cmp({30'h0, hready, hresp}, 32'h2);
    ld(1'b0, 0, 0, 5);
    rdc(awg_pkg::OFF_PTS, 32'h0);
    host.wr(awg_pkg::OFF_TYPE, 32'h0);
    host.wr(awg_pkg::OFF_TYPE, 32'h5);
    rdc(awg_pkg::OFF_TYPE, 32'h10);
    for (int i = 0; i < 4; i++) begin
      v = int'($urandom_range(30000)) - 15000;
      pts[i] = v[15:0];
      ld(1'b1, 0, i, v);
    end
    ld(1'b1, 0, 1600, 0);
    ld(1'b1, 0, 2, -15001);
    ld(1'b1, 0, 5, 15001);
    host.wr(awg_pkg::OFF_PTS, 32'h63);
    rdc(awg_pkg::OFF_PTS, 32'h4);
    host.wr(awg_pkg::OFF_GIDX, 32'h2);
    rdc(awg_pkg::OFF_GDAT, {16'h0, pts[2]});
    host.wr(awg_pkg::OFF_GIDX, 32'h9);
    host.rd(awg_pkg::OFF_GDAT, r);
    cmp({16'h0, r[31:16]}, 32'h1f);
    host.wr(awg_pkg::OFF_DIV, 32'h401);
    rdc(awg_pkg::OFF_DIV, 32'h1);
    host.wr(awg_pkg::OFF_DIV, 32'h2);
    rdc(awg_pkg::OFF_DIV, 32'h2);
    host.wr(awg_pkg::OFF_CYC, 32'h2);
    play(8, 40, 40, 1'b1, 1'b0);
    host.wr(awg_pkg::OFF_DLY, 32'h1);
    host.wr(awg_pkg::OFF_CYC, 32'h1);
    host.wr(awg_pkg::OFF_END, 32'h1);
    play(4, 140, 40, 1'b1, 1'b1);
    host.wr(awg_pkg::OFF_DLY, 32'h0);
    host.wr(awg_pkg::OFF_CYC, 32'h0);
    play(12, 40, 40, 1'b0, 1'b0);
    host.wr(awg_pkg::OFF_RUN, 32'h0);
    repeat (2) @(posedge clk_in);
    cmp({30'h0, loop, running}, 32'h0);
    host.wr(awg_pkg::OFF_CYC, 32'h1);
    host.wr(awg_pkg::OFF_END, 32'h0);
    host.wr(awg_pkg::OFF_RUN, 32'h2);
    sq.delete();
    repeat (3) @(posedge clk_in);
    cmp({25'h0, galv, rng, armed, loop}, 32'h3);
    cmp(sq.size(), 0);
    fall();
    cmp({15'h0, sq.size() == 1, sq[0]}, {15'h0, 1'b1, pts[0]});
    host.wr(awg_pkg::OFF_RUN, 32'h0);
    disarm_try(1'b0);
    disarm_try(1'b1);
    host.wr(awg_pkg::OFF_DIV, 32'h7);
    host.wr(awg_pkg::OFF_RST, 32'h0);
    chk_defaults();
    for (int t = 0; t < 14; t++) begin
      host.wr(awg_pkg::OFF_RST, 32'h0);
      host.wr(awg_pkg::OFF_TYPE, t);
      rdc(awg_pkg::OFF_TYPE, (t <= 10) ? (32'h10 | t) : 32'h0);
    end
    host.wr(awg_pkg::OFF_TYPE, 32'h1);
    ld(1'b1, 1, 0, 1001);
    ld(1'b1, 1, 0, -1000);
    host.wr(awg_pkg::OFF_RUN, 32'h1);
    repeat (2) @(posedge clk_in);
    cmp({27'h0, galv, rng}, 32'h11);
    host.wr(awg_pkg::OFF_RUN, 32'h0);
    host.wr(awg_pkg::OFF_RST, 32'h0);
    host.wr(awg_pkg::OFF_BOOST, 32'h1b);
    host.wr(awg_pkg::OFF_TYPE, 32'h3);
    rdc(awg_pkg::OFF_TYPE, 32'h0);
    host.wr(awg_pkg::OFF_TYPE, 32'hd);
    rdc(awg_pkg::OFF_TYPE, 32'h1d);
    ld(1'b1, 13, 0, -2001);
    ld(1'b1, 13, 0, 2000);
    host.wr(awg_pkg::OFF_RUN, 32'h2);
    repeat (2) @(posedge clk_in);
    cmp({27'h0, galv, rng}, 32'h1d);
    host.wr(awg_pkg::OFF_RUN, 32'h0);
    print_verdict();
  end
endmodule // awg_seq_tb
